// ---- hdl/odp_pkg.sv ----
// Purpose : Constants for the eight-bit open-drain port
// Assumes : AHB-Lite register access, 32-bit data, one word per register
// Notes   : Control register holds only the standby pin-float bit; bit set/clear has its own register
package odp_pkg;
    localparam int unsigned WIDTH        = 8;
    localparam logic [31:0] LATCH_ADDR   = 32'h00000014;
    localparam logic [31:0] CTRL_ADDR    = 32'h00000018;
    localparam logic [31:0] BITOP_ADDR   = 32'h0000001C;
    localparam logic [7:0]  LATCH_RESET  = 8'hFF;
    localparam logic [7:0]  SYNC_RESET   = 8'hFF;
    localparam int unsigned CTRL_FLT_BIT = 0;
    localparam int unsigned BITOP_VAL    = 3;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ   = 2'h3;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
endpackage : odp_pkg

// ---- hdl/odp_port.sv ----
// Purpose : Eight-bit open-drain port with AHB-Lite register access
// Assumes : Pins and resource signals synchronous to clock
// Notes   : Outputs come straight from flip-flops, except hreadyout and hresp, which are tied constant
// Pin map : 0 simple serial clock, 1 data in, 2 data out;
//           3 buffered serial clock, 4 data in, 5 data out; 6,7 plain.
//
// The AHB-Lite interface to the registers is this design's own decision.

// Summary of operation
// - latch bit n controls pin n, bits 0 through 7
// - writing zero stores it and pulls the pin low
// - writing one stores it and releases the pin as input
// - reads return pin levels; a driven-low bit reads zero
// - a released bit reads the external pin level
// - bit set and clear act on latch contents, others unchanged
// - active resource output enable overrides the latch on that pin
// - a resource-driven pin reads back the level being driven
// - pin level feeds resources except in standby with pin-float bit one
// - reset sets every latch bit to one
// - standby with pin-float bit one forces all drivers off
// - standby with pin-float bit one holds input path fixed
// - pull-up option makes released pins rest high
// - latch reads and writes at offset 0x14
// - pins 0-2 simple serial, pins 3-5 buffered serial unit
// - open-drain outputs only, never drive high
module odp_port #(
    parameter bit PULLUP_OPTION = 1'b0
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_n,
    output logic      [7:0]  pin_pullup,
    input  wire logic        standby_mode,
    output logic             standby_pin_float,
    input  wire logic        simple_serial_clock_oe,
    input  wire logic        simple_serial_clock_o,
    input  wire logic        simple_serial_data_out_oe,
    input  wire logic        simple_serial_data_out_o,
    input  wire logic        buffered_serial_clock_oe,
    input  wire logic        buffered_serial_clock_o,
    input  wire logic        buffered_serial_data_out_oe,
    input  wire logic        buffered_serial_data_out_o,
    output logic             simple_serial_clock_i,
    output logic             simple_serial_data_in,
    output logic             buffered_serial_clock_i,
    output logic             buffered_serial_data_in
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic odp_hit(input logic [31:0] a,
                                     input logic [31:0] base);
        odp_hit = (a[31:2] == base[31:2]);
    endfunction : odp_hit

    // ------------------------------------------------------------
    // Resource overrides
    // ------------------------------------------------------------
    logic [7:0] res_oe;
    logic [7:0] res_val;
    always_comb begin
        res_oe  = 8'h00; // Pins 6 and 7 have no resource
        res_val = 8'hFF;
        res_oe[0]  = simple_serial_clock_oe;
        res_val[0] = simple_serial_clock_o;
        res_oe[2]  = simple_serial_data_out_oe;
        res_val[2] = simple_serial_data_out_o;
        res_oe[3]  = buffered_serial_clock_oe;
        res_val[3] = buffered_serial_clock_o;
        res_oe[5]  = buffered_serial_data_out_oe;
        res_val[5] = buffered_serial_data_out_o;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    logic [7:0]  latch_reg,    latch_next;
    logic        float_reg,    float_next;
    logic [7:0]  sync1_reg,    sync1_next;
    logic [7:0]  sync2_reg,    sync2_next;
    logic        wr_pend_reg,  wr_pend_next;
    logic [1:0]  wr_sel_reg,   wr_sel_next;
    logic [31:0] hrdata_reg,   hrdata_next;
    logic [7:0]  oe_n_reg,     oe_n_next;
    logic [7:0]  pout_reg,     pout_next;
    logic [7:0]  pull_reg,     pull_next;
    logic [3:0]  res_in_reg,   res_in_next;
    logic        float_out_reg;
    logic        float_active;
    logic        addr_ok;

    assign float_active = standby_mode && float_reg;
    assign addr_ok = hsel && hready && (htrans == odp_pkg::HTRANS_NSEQ ||
                     htrans == odp_pkg::HTRANS_SEQ);

    // Bus slave, latch and control next-state
    always_comb begin
        latch_next   = latch_reg;
        float_next   = float_reg;
        wr_pend_next = 1'b0;
        wr_sel_next  = wr_sel_reg;
        hrdata_next  = 32'h00000000;
        if (wr_pend_reg) begin
            unique case (wr_sel_reg)
                2'h1: latch_next = hwdata[7:0];
                2'h2: float_next = hwdata[odp_pkg::CTRL_FLT_BIT];
                2'h3: latch_next[hwdata[2:0]] =
                          hwdata[odp_pkg::BITOP_VAL];
                default: latch_next = latch_reg;
            endcase
        end
        if (addr_ok && hwrite) begin
            wr_pend_next = 1'b1;
            if (odp_hit(haddr, odp_pkg::LATCH_ADDR))
                wr_sel_next = 2'h1;
            else if (odp_hit(haddr, odp_pkg::CTRL_ADDR))
                wr_sel_next = 2'h2;
            else if (odp_hit(haddr, odp_pkg::BITOP_ADDR))
                wr_sel_next = 2'h3;
            else
                wr_sel_next = 2'h0; // Unmapped write ignored
        end else if (addr_ok) begin
            if (odp_hit(haddr, odp_pkg::LATCH_ADDR))
                hrdata_next = {24'h000000, sync2_reg};
            else if (odp_hit(haddr, odp_pkg::CTRL_ADDR))
                hrdata_next = {31'h00000000, float_reg};
            else if (odp_hit(haddr, odp_pkg::BITOP_ADDR))
                hrdata_next = {24'h000000, latch_reg};
        end
    end

    // Pin drive, pull-up and resource input next-state
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Open drain: only ever drives low
            pout_next[i] = 1'b0;
            if (float_active)
                oe_n_next[i] = 1'b1;
            else if (res_oe[i])
                oe_n_next[i] = res_val[i];
            else
                oe_n_next[i] = latch_next[i];
            pull_next[i] = PULLUP_OPTION;
        end
        sync1_next = pin_in;
        sync2_next = sync1_reg;
        if (float_active)
            res_in_next = 4'hF;
        else
            res_in_next = {sync2_reg[4], sync2_reg[3],
                           sync2_reg[1], sync2_reg[0]};
    end

    // Registers
    always_ff @(posedge clock) begin
        if (srst) begin
            latch_reg     <= odp_pkg::LATCH_RESET;
            float_reg     <= 1'b0;
            sync1_reg     <= odp_pkg::SYNC_RESET;
            sync2_reg     <= odp_pkg::SYNC_RESET;
            wr_pend_reg   <= 1'b0;
            wr_sel_reg    <= 2'h0;
            hrdata_reg    <= 32'h00000000;
            oe_n_reg      <= 8'hFF;
            pout_reg      <= 8'h00;
            pull_reg      <= 8'h00;
            res_in_reg    <= 4'hF;
            float_out_reg <= 1'b0;
        end else begin
            latch_reg     <= latch_next;
            float_reg     <= float_next;
            sync1_reg     <= sync1_next;
            sync2_reg     <= sync2_next;
            wr_pend_reg   <= wr_pend_next;
            wr_sel_reg    <= wr_sel_next;
            hrdata_reg    <= hrdata_next;
            oe_n_reg      <= oe_n_next;
            pout_reg      <= pout_next;
            pull_reg      <= pull_next;
            res_in_reg    <= res_in_next;
            float_out_reg <= float_next;
        end
    end

    // Outputs straight from flip-flops; hreadyout and hresp tied constant
    assign hrdata                  = hrdata_reg;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign pin_out                 = pout_reg;
    assign pin_oe_n                = oe_n_reg;
    assign pin_pullup              = pull_reg;
    assign standby_pin_float       = float_out_reg;
    assign simple_serial_clock_i   = res_in_reg[0];
    assign simple_serial_data_in   = res_in_reg[1];
    assign buffered_serial_clock_i = res_in_reg[2];
    assign buffered_serial_data_in = res_in_reg[3];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_float;
        @(posedge clock) $fell(srst) |-> latch_reg == 8'hFF;
    endproperty
    a_reset_float: assert property (p_reset_float)
        else $error("latch not all ones after reset");

    property p_write_latch;
        @(posedge clock) disable iff (srst)
        (addr_ok && hwrite && odp_hit(haddr, odp_pkg::LATCH_ADDR))
        ##1 1'b1 |=> latch_reg == $past(hwdata[7:0]);
    endproperty
    a_write_latch: assert property (p_write_latch)
        else $error("latch write not stored");

    property p_never_high;
        @(posedge clock) disable iff (srst) pin_out == 8'h00;
    endproperty
    a_never_high: assert property (p_never_high)
        else $error("port drives high");

    property p_standby_off;
        @(posedge clock) disable iff (srst)
        float_active |=> pin_oe_n == 8'hFF && res_in_reg == 4'hF;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("drivers not off in standby");

    property p_latch_drive;
        @(posedge clock) disable iff (srst)
        (!float_active && res_oe == 8'h00) |=>
        pin_oe_n == $past(latch_next);
    endproperty
    a_latch_drive: assert property (p_latch_drive)
        else $error("driver does not follow latch");

    property p_res_over;
        @(posedge clock) disable iff (srst)
        (!float_active && res_oe[2]) |=> pin_oe_n[2] == $past(res_val[2]);
    endproperty
    a_res_over: assert property (p_res_over)
        else $error("resource output not given priority");

    property p_read_pins;
        @(posedge clock) disable iff (srst)
        (addr_ok && !hwrite && odp_hit(haddr, odp_pkg::LATCH_ADDR))
        |=> hrdata[7:0] == $past(pin_in, 3);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("read does not return synchronised pins");

    property p_res_in;
        @(posedge clock) disable iff (srst)
        !float_active |=> simple_serial_data_in == $past(sync2_reg[1]);
    endproperty
    a_res_in: assert property (p_res_in)
        else $error("resource input not passed through");

    property p_reset_drivers;
        @(posedge clock) srst |=>
        pin_oe_n == 8'hFF && latch_reg == odp_pkg::LATCH_RESET;
    endproperty
    a_reset_drivers: assert property (p_reset_drivers)
        else $error("drivers not released by reset");

    property p_pullup;
        @(posedge clock) disable iff (srst)
        !srst |=> pin_pullup == {8{PULLUP_OPTION}};
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enable does not match option");

    property p_bitop_keep;
        @(posedge clock) disable iff (srst)
        (wr_pend_reg && wr_sel_reg == 2'h3) |=>
        ((latch_reg ^ $past(latch_reg)) &
         ~(8'h01 << $past(hwdata[2:0]))) == 8'h00;
    endproperty
    a_bitop_keep: assert property (p_bitop_keep)
        else $error("bit operation disturbed other latch bits");

    property p_write_ctrl;
        @(posedge clock) disable iff (srst)
        (wr_pend_reg && wr_sel_reg == 2'h2) |=>
        standby_pin_float == $past(hwdata[odp_pkg::CTRL_FLT_BIT]);
    endproperty
    a_write_ctrl: assert property (p_write_ctrl)
        else $error("pin-float control bit not stored");

    // Main scenarios: writes, standby, resource drive, bit ops, reset
    c_write: cover property (@(posedge clock) wr_pend_reg);
    c_standby: cover property (@(posedge clock) float_active);
    c_res: cover property (@(posedge clock) res_oe[5]);
    c_bitop: cover property (@(posedge clock)
        wr_pend_reg && wr_sel_reg == 2'h3);
    c_reset_release: cover property (@(posedge clock) $fell(srst));

endmodule : odp_port

// ---- verification/odp_pins_model.sv ----
// Purpose : Board around the port: pull-ups and external pull-down drivers
// Assumes : Pull-up resistors fitted on every pin
// Notes   : Wire level is resolved from every party's drive
module odp_pins_model (
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] ext_low,
    output logic      [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND of port drive and external drivers; released lines go high
    assign pin_level = ~ext_low & (pin_oe_n | pin_out);
endmodule : odp_pins_model

// ---- verification/test_open_drain_port_eight_bit.sv ----
// Purpose : Self-checking bench for the open-drain port
// Assumes : Single AHB-Lite master, zero-wait slave
// Notes   : Pin levels settle through a two-flop synchroniser
module test_open_drain_port_eight_bit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup;
    logic [7:0]  ext_low = 8'h00;
    logic        standby_mode = 1'b0;
    logic        spf;
    logic [3:0]  res_oe = 4'h0;
    logic [3:0]  res_o = 4'h0;
    logic [3:0]  res_in;
    logic [7:0]  e;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // ----------------------------------------------------------------
    // Clock, timeout, design and board
    // ----------------------------------------------------------------
    always #4 clock = ~clock;
    // Cuts a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end
    odp_port #(.PULLUP_OPTION(1'b1)) dut (
        .clock(clock), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(odp_pkg::HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
        .standby_mode(standby_mode), .standby_pin_float(spf),
        .simple_serial_clock_oe(res_oe[0]),
        .simple_serial_clock_o(res_o[0]),
        .simple_serial_data_out_oe(res_oe[1]),
        .simple_serial_data_out_o(res_o[1]),
        .buffered_serial_clock_oe(res_oe[2]),
        .buffered_serial_clock_o(res_o[2]),
        .buffered_serial_data_out_oe(res_oe[3]),
        .buffered_serial_data_out_o(res_o[3]),
        .simple_serial_clock_i(res_in[0]),
        .simple_serial_data_in(res_in[1]),
        .buffered_serial_clock_i(res_in[2]),
        .buffered_serial_data_in(res_in[3]));
    odp_pins_model board (.pin_oe_n(pin_oe_n), .pin_out(pin_out),
        .ext_low(ext_low), .pin_level(pin_in));
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== ex) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= odp_pkg::HTRANS_NSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        repeat (4) @(posedge clock);
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk("hrdata", ex, r);
    endtask : rd_chk
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        chk("pin_oe_n", 32'hFF, pin_oe_n);
        chk("pin_pullup", 32'hFF, pin_pullup);
        rd_chk(odp_pkg::LATCH_ADDR, 32'hFF);
        rd_chk(odp_pkg::CTRL_ADDR, 32'h0);
        for (int n = 0; n < 8; n++) begin
            e = 8'hFF ^ (8'h01 << n);
            wr(odp_pkg::LATCH_ADDR, {24'h0, e});
            chk("pin_oe_n", {24'h0, e}, pin_oe_n);
            chk("pin_out", 32'h0, pin_out);
            rd_chk(odp_pkg::LATCH_ADDR, {24'h0, e});
        end
        wr(odp_pkg::LATCH_ADDR, 32'hFF);
        ext_low <= 8'h40;
        repeat (4) @(posedge clock);
        rd_chk(odp_pkg::LATCH_ADDR, 32'hBF);
        wr(odp_pkg::LATCH_ADDR, 32'hF0);
        wr(odp_pkg::BITOP_ADDR, 32'h8);
        chk("pin_oe_n", 32'hF1, pin_oe_n);
        rd_chk(odp_pkg::BITOP_ADDR, 32'hF1);
        ext_low <= 8'h00;
        wr(odp_pkg::LATCH_ADDR, 32'h00);
        res_oe <= 4'hF;
        res_o  <= 4'hF;
        repeat (4) @(posedge clock);
        chk("pin_oe_n", 32'h2D, pin_oe_n);
        rd_chk(odp_pkg::LATCH_ADDR, 32'h2D);
        wr(odp_pkg::LATCH_ADDR, 32'hFF);
        res_o <= 4'h0;
        repeat (4) @(posedge clock);
        chk("pin_oe_n", 32'hD2, pin_oe_n);
        rd_chk(odp_pkg::LATCH_ADDR, 32'hD2);
        res_oe <= 4'h0;
        ext_low <= 8'h1B;
        repeat (4) @(posedge clock);
        chk("res_in", 32'h0, res_in);
        wr(odp_pkg::CTRL_ADDR, 32'h1);
        wr(odp_pkg::LATCH_ADDR, 32'h00);
        standby_mode <= 1'b1;
        repeat (4) @(posedge clock);
        chk("standby_pin_float", 32'h1, spf);
        chk("pin_oe_n", 32'hFF, pin_oe_n);
        chk("res_in", 32'hF, res_in);
        standby_mode <= 1'b0;
        repeat (4) @(posedge clock);
        chk("pin_oe_n", 32'h00, pin_oe_n);
        chk("res_in", 32'h0, res_in);
        wr(32'h20, 32'hFF);
        rd_chk(32'h20, 32'h0);
        rd_chk(odp_pkg::BITOP_ADDR, 32'h00);
        chk("hresp", 32'h0, hresp);
        // Mid-run reset with the latch driving every pin low
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        chk("pin_oe_n", 32'hFF, pin_oe_n);
        rd_chk(odp_pkg::BITOP_ADDR, 32'hFF);
        rd_chk(odp_pkg::CTRL_ADDR, 32'h0);
        close_out();
    end
endmodule : test_open_drain_port_eight_bit
